// ---- hw/crinit_regs.vh ----
// Offsets, fields and timing counts for the initialization controller
`ifndef CRINIT_REGS_VH
`define CRINIT_REGS_VH

// Controller registers, byte offsets on the AXI4-Lite slave
`define CRI_OFS_CTRL        8'h00
`define CRI_OFS_STATUS      8'h04
`define CRI_OFS_BRIDGE      8'h08
`define CRI_OFS_MASK_LO     8'h0c
`define CRI_OFS_MASK_HI     8'h10
`define CRI_OFS_ACC_ADDR    8'h14
`define CRI_OFS_ACC_WDATA   8'h18
`define CRI_OFS_ACC_GO      8'h1c
`define CRI_OFS_ACC_RDATA   8'h20

// Control register fields and access address read-select bit
`define CRI_CTRL_START      0
`define CRI_CTRL_SWRST      1
`define CRI_CTRL_FINISH     2
`define CRI_ACC_RD_BIT      16

// Device-side register addresses (16-bit registers)
`define CRI_DEV_RESET_ID    16'h0000
`define CRI_DEV_MASTER_CFG  16'h0010
`define CRI_DEV_BRIDGE      16'h0040
`define CRI_DEV_RDMA_SEL    16'h0770
`define CRI_DEV_RDMA_DATA   16'h0774
`define CRI_DEV_TDMA_SEL    16'h0870
`define CRI_DEV_TDMA_DATA   16'h0874

// Device field positions
`define CRI_DEV_RST_BIT     0
`define CRI_DEV_RDE_BIT     0
`define CRI_DEV_TDE_BIT     1
`define CRI_DEV_CHEN_BIT    0

// Sizes
`define CRI_NUM_CHAN        40
`define CRI_LAST_CHAN       6'd39

// Timing: hardware reset pulse width and clock period, in ns
`define CRI_HWRST_NS        1000
`define CRI_CLK_NS          40
`define CRI_HWRST_CYC       ((`CRI_HWRST_NS + `CRI_CLK_NS - 1) / `CRI_CLK_NS)

`endif

// ---- hw/crinit_host.v ----
// Host-side initialization controller: AXI4-Lite slave, sequencer and device register port
`timescale 1ns/1ps
//
// Contract
// - Every device access carries at least one asserted byte enable.
// - Reserved bits kept unmodified; read values of them carry no meaning.
// - Host brings all internal registers to known state before traffic.
// - Start with reset, then bridge-mode register, then assert config select.
// - Fourth step clears channel enable in receive and transmit DMA RAMs.
// - Then receive DMA RAM, receive FIFO, receive port control, in order.
// - Then transmit DMA, transmit FIFO, tx HDLC, tx port, rx HDLC control.
// - Then set channel enables in receive DMA RAM, then transmit.
// - Optionally interrupts; last set both global DMA enables in master config.
// - Host writes only one rx and one tx DMA register per channel; code writes data then select, two per channel, enable passes masked channels only.
`include "crinit_regs.vh"

module crinit_host (
  clk,
  rst_n,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  hw_reset_pin_n,
  config_select_input,
  dev_addr,
  dev_wdata,
  cmd_byte_enable_lines,
  dev_wr,
  dev_rd,
  dev_ack,
  dev_rdata
);
  input  wire        clk;
  input  wire        rst_n;
  input  wire [7:0]  s_axi_awaddr;
  input  wire        s_axi_awvalid;
  output reg         s_axi_awready;
  input  wire [31:0] s_axi_wdata;
  input  wire [3:0]  s_axi_wstrb;
  input  wire        s_axi_wvalid;
  output reg         s_axi_wready;
  output reg  [1:0]  s_axi_bresp;
  output reg         s_axi_bvalid;
  input  wire        s_axi_bready;
  input  wire [7:0]  s_axi_araddr;
  input  wire        s_axi_arvalid;
  output reg         s_axi_arready;
  output reg  [31:0] s_axi_rdata;
  output reg  [1:0]  s_axi_rresp;
  output reg         s_axi_rvalid;
  input  wire        s_axi_rready;
  output reg         hw_reset_pin_n;
  output reg         config_select_input;
  output reg  [15:0] dev_addr;
  output reg  [15:0] dev_wdata;
  output reg  [3:0]  cmd_byte_enable_lines;
  output reg         dev_wr;
  output reg         dev_rd;
  input  wire        dev_ack;
  input  wire [15:0] dev_rdata;

  localparam [3:0] S_IDLE   = 4'h0;
  localparam [3:0] S_HWRST  = 4'h1;
  localparam [3:0] S_SWRST  = 4'h2;
  localparam [3:0] S_BRIDGE = 4'h3;
  localparam [3:0] S_CFGSEL = 4'h4;
  localparam [3:0] S_DISRX  = 4'h5;
  localparam [3:0] S_DISTX  = 4'h6;
  localparam [3:0] S_SETUP  = 4'h7;
  localparam [3:0] S_ENRX   = 4'h8;
  localparam [3:0] S_ENTX   = 4'h9;
  localparam [3:0] S_MCRD   = 4'ha;
  localparam [3:0] S_MCWR   = 4'hb;
  localparam [3:0] S_DONE   = 4'hc;

  localparam [1:0] A_IDLE = 2'h0;
  localparam [1:0] A_REQ  = 2'h1;
  localparam [1:0] A_REL  = 2'h2;

  localparam integer RST_LAST = `CRI_HWRST_CYC;
  localparam [15:0] CHEN_VAL = 16'h0001 << `CRI_DEV_CHEN_BIT;
  localparam [15:0] MC_EN    = (16'h0001 << `CRI_DEV_RDE_BIT) | (16'h0001 << `CRI_DEV_TDE_BIT);
  localparam [15:0] RST_VAL  = 16'h0001 << `CRI_DEV_RST_BIT;

  // Byte-lane merge for software writes
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `CRI_OFS_ACC_RDATA);
    end
  endfunction

  // Software-visible state
  reg        sw_sel_r;
  reg [15:0] bridge_val_r;
  reg [31:0] mask_lo_r;
  reg [7:0]  mask_hi_r;
  reg [16:0] acc_addr_r;
  reg [15:0] acc_wdata_r;
  reg [15:0] acc_rdata_r;
  reg        start_cmd_r;
  reg        finish_cmd_r;
  reg        go_cmd_r;

  // AXI write channel bookkeeping
  reg        aw_got_r;
  reg        w_got_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;

  // Sequencer and access engine
  reg [3:0]  st_r;
  reg [4:0]  cnt_r;
  reg [5:0]  ch_r;
  reg        half_r;
  reg        pend_r;
  reg        acc_go_r;
  reg        acc_rd_r;
  reg [15:0] acc_a_r;
  reg [15:0] acc_d_r;
  reg [1:0]  a_st_r;
  reg        acc_done_r;
  reg [15:0] acc_q_r;
  reg [15:0] mc_val_r;
  reg        ack_m_r;
  reg        ack_s_r;
  reg [15:0] rdata_m_r;
  reg [15:0] rdata_s_r;

  wire [39:0] chan_mask = {mask_hi_r, mask_lo_r};
  wire        busy      = (st_r != S_IDLE) && (st_r != S_DONE);
  wire        wr_fire   = aw_got_r && w_got_r && !s_axi_bvalid;
  wire [31:0] mrg_bridge = merge({16'h0000, bridge_val_r}, w_data_r, w_strb_r);
  wire [31:0] mrg_addr   = merge({15'h0000, acc_addr_r}, w_data_r, w_strb_r);
  wire [31:0] mrg_wdata  = merge({16'h0000, acc_wdata_r}, w_data_r, w_strb_r);

  // Device pins cross into this clock domain
  always @(posedge clk) begin
    if (!rst_n) begin
      ack_m_r   <= 1'b0;
      ack_s_r   <= 1'b0;
      rdata_m_r <= 16'h0000;
      rdata_s_r <= 16'h0000;
    end else begin
      ack_m_r   <= dev_ack;
      ack_s_r   <= ack_m_r;
      rdata_m_r <= dev_rdata;
      rdata_s_r <= rdata_m_r;
    end
  end

  // AXI4-Lite write side
  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      sw_sel_r      <= 1'b0;
      bridge_val_r  <= 16'h0000;
      mask_lo_r     <= 32'h00000000;
      mask_hi_r     <= 8'h00;
      acc_addr_r    <= 17'h00000;
      acc_wdata_r   <= 16'h0000;
      start_cmd_r   <= 1'b0;
      finish_cmd_r  <= 1'b0;
      go_cmd_r      <= 1'b0;
    end else begin
      start_cmd_r  <= 1'b0;
      finish_cmd_r <= 1'b0;
      go_cmd_r     <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? 2'b00 : 2'b10;
        case (aw_addr_r)
          `CRI_OFS_CTRL: begin
            if (w_strb_r[0]) begin
              sw_sel_r     <= w_data_r[`CRI_CTRL_SWRST];
              start_cmd_r  <= w_data_r[`CRI_CTRL_START];
              finish_cmd_r <= w_data_r[`CRI_CTRL_FINISH];
            end
          end
          `CRI_OFS_BRIDGE:    bridge_val_r <= mrg_bridge[15:0];
          `CRI_OFS_MASK_LO:   mask_lo_r    <= merge(mask_lo_r, w_data_r, w_strb_r);
          `CRI_OFS_MASK_HI:   mask_hi_r    <= w_strb_r[0] ? w_data_r[7:0] : mask_hi_r;
          `CRI_OFS_ACC_ADDR:  acc_addr_r   <= mrg_addr[16:0];
          `CRI_OFS_ACC_WDATA: acc_wdata_r  <= mrg_wdata[15:0];
          `CRI_OFS_ACC_GO:    go_cmd_r     <= 1'b1;
          default: begin
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read side
  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        `CRI_OFS_CTRL:      s_axi_rdata <= {30'h00000000, sw_sel_r, 1'b0};
        `CRI_OFS_STATUS:    s_axi_rdata <= {20'h00000, st_r, 4'h0, pend_r, st_r == S_SETUP, st_r == S_DONE, busy};
        `CRI_OFS_BRIDGE:    s_axi_rdata <= {16'h0000, bridge_val_r};
        `CRI_OFS_MASK_LO:   s_axi_rdata <= mask_lo_r;
        `CRI_OFS_MASK_HI:   s_axi_rdata <= {24'h000000, mask_hi_r};
        `CRI_OFS_ACC_ADDR:  s_axi_rdata <= {15'h0000, acc_addr_r};
        `CRI_OFS_ACC_WDATA: s_axi_rdata <= {16'h0000, acc_wdata_r};
        `CRI_OFS_ACC_RDATA: s_axi_rdata <= {16'h0000, acc_rdata_r};
        default:            s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Four-phase device access; request held until the synced ack rises
  always @(posedge clk) begin
    if (!rst_n) begin
      a_st_r                <= A_IDLE;
      dev_addr              <= 16'h0000;
      dev_wdata             <= 16'h0000;
      dev_wr                <= 1'b0;
      dev_rd                <= 1'b0;
      cmd_byte_enable_lines <= 4'h0;
      acc_done_r            <= 1'b0;
      acc_q_r               <= 16'h0000;
    end else begin
      acc_done_r <= 1'b0;
      case (a_st_r)
        A_IDLE: begin
          if (acc_go_r) begin
            dev_addr  <= acc_a_r;
            dev_wdata <= acc_d_r;
            dev_wr    <= !acc_rd_r;
            dev_rd    <= acc_rd_r;
            cmd_byte_enable_lines <= 4'hf;
            a_st_r <= A_REQ;
          end
        end
        A_REQ: begin
          if (ack_s_r) begin
            dev_wr                <= 1'b0;
            dev_rd                <= 1'b0;
            cmd_byte_enable_lines <= 4'h0;
            acc_q_r               <= rdata_s_r;
            a_st_r                <= A_REL;
          end
        end
        A_REL: begin
          if (!ack_s_r) begin
            acc_done_r <= 1'b1;
            a_st_r     <= A_IDLE;
          end
        end
        default: a_st_r <= A_IDLE;
      endcase
    end
  end

  // Initialization sequencer
  always @(posedge clk) begin
    if (!rst_n) begin
      st_r                <= S_IDLE;
      cnt_r               <= 5'd0;
      ch_r                <= 6'd0;
      half_r              <= 1'b0;
      pend_r              <= 1'b0;
      acc_go_r            <= 1'b0;
      acc_rd_r            <= 1'b0;
      acc_a_r             <= 16'h0000;
      acc_d_r             <= 16'h0000;
      mc_val_r            <= 16'h0000;
      acc_rdata_r         <= 16'h0000;
      hw_reset_pin_n      <= 1'b0;
      config_select_input <= 1'b0;
    end else begin
      acc_go_r <= 1'b0;
      if (acc_done_r) begin
        pend_r <= 1'b0;
      end
      case (st_r)
        S_IDLE, S_DONE: begin
          hw_reset_pin_n <= 1'b1;
          if (start_cmd_r) begin
            cnt_r  <= 5'd0;
            ch_r   <= 6'd0;
            half_r <= 1'b0;
            st_r   <= sw_sel_r ? S_SWRST : S_HWRST;
            config_select_input <= 1'b0;
          end
        end
        S_HWRST: begin
          hw_reset_pin_n <= 1'b0;
          cnt_r <= cnt_r + 5'd1;
          if (cnt_r == RST_LAST[4:0]) begin
            hw_reset_pin_n <= 1'b1;
            st_r <= S_BRIDGE;
          end
        end
        S_SWRST: begin
          if (!pend_r && !acc_done_r) begin
            acc_go_r <= 1'b1;
            pend_r   <= 1'b1;
            acc_rd_r <= 1'b0;
            acc_a_r  <= `CRI_DEV_RESET_ID;
            acc_d_r  <= half_r ? 16'h0000 : RST_VAL;
          end else if (acc_done_r) begin
            half_r <= !half_r;
            if (half_r) begin
              st_r <= S_BRIDGE;
            end
          end
        end
        S_BRIDGE: begin
          // bridge value rewritten after any reset
          if (!pend_r && !acc_done_r) begin
            acc_go_r <= 1'b1;
            pend_r   <= 1'b1;
            acc_rd_r <= 1'b0;
            acc_a_r  <= `CRI_DEV_BRIDGE;
            acc_d_r  <= bridge_val_r;
          end else if (acc_done_r) begin
            st_r <= S_CFGSEL;
          end
        end
        S_CFGSEL: begin
          config_select_input <= 1'b1;
          ch_r   <= 6'd0;
          half_r <= 1'b0;
          st_r   <= S_DISRX;
        end
        S_DISRX, S_DISTX, S_ENRX, S_ENTX: begin
          // one entry per channel (per masked channel when enabling), data then select
          if ((st_r == S_ENRX || st_r == S_ENTX) && !chan_mask[ch_r] && !pend_r) begin
            ch_r <= ch_r + 6'd1;
            if (ch_r == `CRI_LAST_CHAN) begin
              ch_r <= 6'd0;
              st_r <= st_r + 4'd1;
            end
          end else if (!pend_r && !acc_done_r) begin
            acc_go_r <= 1'b1;
            pend_r   <= 1'b1;
            acc_rd_r <= 1'b0;
            if (st_r == S_DISRX || st_r == S_ENRX) begin
              acc_a_r <= half_r ? `CRI_DEV_RDMA_SEL : `CRI_DEV_RDMA_DATA;
            end else begin
              acc_a_r <= half_r ? `CRI_DEV_TDMA_SEL : `CRI_DEV_TDMA_DATA;
            end
            if (half_r) begin
              acc_d_r <= {10'h000, ch_r};
            end else begin
              acc_d_r <= (st_r == S_ENRX || st_r == S_ENTX) ? CHEN_VAL : 16'h0000;
            end
          end else if (acc_done_r) begin
            half_r <= !half_r;
            if (half_r) begin
              ch_r <= ch_r + 6'd1;
              if (ch_r == `CRI_LAST_CHAN) begin
                ch_r <= 6'd0;
                st_r <= (st_r == S_DISTX) ? S_SETUP : st_r + 4'd1;
              end
            end
          end
        end
        S_SETUP: begin
          // software programs its own order here
          if (acc_done_r) begin
            acc_rdata_r <= acc_q_r;
          end
          if (go_cmd_r && !pend_r) begin
            acc_go_r <= 1'b1;
            pend_r   <= 1'b1;
            acc_rd_r <= acc_addr_r[`CRI_ACC_RD_BIT];
            acc_a_r  <= acc_addr_r[15:0];
            acc_d_r  <= acc_wdata_r;
          end else if (finish_cmd_r && !pend_r && !acc_done_r) begin
            ch_r   <= 6'd0;
            half_r <= 1'b0;
            st_r   <= S_ENRX;
          end
        end
        S_MCRD: begin
          // read first so other bits go back unchanged
          if (!pend_r && !acc_done_r) begin
            acc_go_r <= 1'b1;
            pend_r   <= 1'b1;
            acc_rd_r <= 1'b1;
            acc_a_r  <= `CRI_DEV_MASTER_CFG;
          end else if (acc_done_r) begin
            mc_val_r <= acc_q_r;
            st_r     <= S_MCWR;
          end
        end
        S_MCWR: begin
          if (!pend_r && !acc_done_r) begin
            acc_go_r <= 1'b1;
            pend_r   <= 1'b1;
            acc_rd_r <= 1'b0;
            acc_a_r  <= `CRI_DEV_MASTER_CFG;
            acc_d_r  <= mc_val_r | MC_EN;
          end else if (acc_done_r) begin
            st_r <= S_DONE;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

endmodule

// ---- tb/crinit_host_properties.sv ----
// Port-level assertions for the initialization controller
`timescale 1ns/1ps
module crinit_host_chk (
  input wire        clk,
  input wire        rst_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        hw_reset_pin_n,
  input wire        config_select_input,
  input wire [15:0] dev_addr,
  input wire [15:0] dev_wdata,
  input wire [3:0]  cmd_byte_enable_lines,
  input wire        dev_wr,
  input wire        dev_rd,
  input wire        dev_ack
);
  logic [5:0] lo_cnt_r;
  wire        req_w = dev_wr | dev_rd;

  // Reset pin low time
  always @(posedge clk) begin
    if (!rst_n || hw_reset_pin_n) begin
      lo_cnt_r <= 6'h00;
    end else begin
      lo_cnt_r <= lo_cnt_r + 6'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_be_active: assert property (req_w |-> cmd_byte_enable_lines == 4'hf)
    else $error("byte enables not all set during a request");
  a_req_hold: assert property (req_w && !dev_ack |=> $stable({dev_wr, dev_rd, dev_addr, dev_wdata}))
    else $error("request changed before acknowledge");
  a_wr_rd_excl: assert property (!(dev_wr && dev_rd))
    else $error("read and write requested together");
  a_ack_drop: assert property ($rose(dev_ack) |-> req_w [*2] ##[1:2] !req_w)
    else $error("request held too long after acknowledge");
  a_gap_after: assert property ($fell(dev_ack) |-> !req_w [*3])
    else $error("request too soon after acknowledge");
  a_hwrst_width: assert property ($rose(hw_reset_pin_n) |-> lo_cnt_r == 6'd25 || lo_cnt_r == 6'd1)
    else $error("hardware reset pulse width wrong");
  a_cfgsel_quiet: assert property ($rose(config_select_input) |-> hw_reset_pin_n && !req_w)
    else $error("config select raised too early");
  a_bresp_next: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rvalid_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not closed after handshake");

  c_dev_write: cover property (dev_wr && dev_ack);
  c_cfgsel: cover property ($rose(config_select_input));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind crinit_host crinit_host_chk i_crinit_host_chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .hw_reset_pin_n, .config_select_input, .dev_addr, .dev_wdata, .cmd_byte_enable_lines, .dev_wr, .dev_rd, .dev_ack);

// ---- tb/crinit_dev_model.sv ----
// Behavioural model of the device register port
`timescale 1ns/1ps
`include "crinit_regs.vh"
module crinit_dev_model (
  input  wire         clk,
  input  wire         hw_reset_pin_n,
  input  wire  [15:0] dev_addr,
  input  wire  [15:0] dev_wdata,
  input  wire  [3:0]  cmd_byte_enable_lines,
  input  wire         dev_wr,
  input  wire         dev_rd,
  output logic        dev_ack,
  output logic [15:0] dev_rdata
);
  localparam int BR_IX = `CRI_DEV_BRIDGE >> 2;
  logic [15:0] dreg [0:1023];
  logic        rx_en [0:39];
  logic        tx_en [0:39];
  logic [15:0] wlog [$];
  logic [15:0] last_q;
  int          wait_cnt;
  int          slow;
  int          bad_cnt;

  // idle start; garbage shows each clear
  initial begin
    dev_ack = 1'b0;
    last_q = 16'h0000;
    dev_rdata = 16'hffff;
    wait_cnt = 0;
    slow = 0;
    bad_cnt = 0;
    for (int i = 0; i < 1024; i++) dreg[i] = 16'hffff;
    for (int i = 0; i < 40; i++) rx_en[i] = 1'b1;
    for (int i = 0; i < 40; i++) tx_en[i] = 1'b1;
  end

  task automatic do_write(input logic [15:0] a, input logic [15:0] d);
    wlog.push_back(a);
    // one enable entry per channel, 40 channels
    if (a == `CRI_DEV_RDMA_SEL || a == `CRI_DEV_TDMA_SEL) begin
      if (d > 16'd39) bad_cnt <= bad_cnt + 1;
      else if (a == `CRI_DEV_RDMA_SEL) rx_en[d[5:0]] <= dreg[`CRI_DEV_RDMA_DATA >> 2][0];
      else tx_en[d[5:0]] <= dreg[`CRI_DEV_TDMA_DATA >> 2][0];
    // software reset spares bridge and indirect state
    end else if (a == `CRI_DEV_RESET_ID && d[`CRI_DEV_RST_BIT]) begin
      for (int i = 0; i < 1024; i++) if (i != BR_IX) dreg[i] <= 16'h0000;
    end else begin
      dreg[a[11:2]] <= d;
    end
  endtask

  // Alternates prompt and slow acknowledges
  always @(posedge clk) begin
    // hardware reset clears all direct registers
    if (!hw_reset_pin_n) begin
      for (int i = 0; i < 1024; i++) dreg[i] <= 16'h0000;
      dev_ack <= 1'b0;
    end else if (!dev_ack && (dev_wr || dev_rd)) begin
      if (wait_cnt < slow) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        slow <= (slow == 0) ? 5 : 0;
        dev_ack <= 1'b1;
        if (cmd_byte_enable_lines == 4'h0) bad_cnt <= bad_cnt + 1;
        else if (dev_rd) begin
          dev_rdata <= dreg[dev_addr[11:2]];
          last_q <= dreg[dev_addr[11:2]];
        end else do_write(dev_addr, dev_wdata);
      end
    end else if (dev_ack && !dev_wr && !dev_rd) begin
      dev_ack <= 1'b0;
      dev_rdata <= ~last_q;
    end
  end
endmodule

// ---- tb/crinit_host_test.sv ----
// Self-checking bench for the initialization controller
`timescale 1ns/1ps
`include "crinit_regs.vh"
module crinit_host_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         hw_reset_pin_n, config_select_input, dev_wr, dev_rd, dev_ack;
  wire  [15:0] dev_addr, dev_wdata, dev_rdata;
  wire  [3:0]  cmd_byte_enable_lines;
  int          fail_count = 0;
  int          total_checks = 0;
  int          hw_falls = 0;
  int          n;
  logic [31:0] d;
  logic [1:0]  r;
  int          ix [7] = '{0, 1, 2, 81, 162, 168, 174};
  logic [15:0] ex [7] = '{16'h0040, 16'h0774, 16'h0770, 16'h0874, 16'h0774, 16'h0874, 16'h0010};

  always #20 clk = ~clk;
  always @(negedge hw_reset_pin_n) if (rst_n) hw_falls++;

  crinit_host i_crinit_host (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hw_reset_pin_n, .config_select_input,
    .dev_addr, .dev_wdata, .cmd_byte_enable_lines, .dev_wr, .dev_rd, .dev_ack, .dev_rdata);
  crinit_dev_model i_crinit_dev_model (.clk, .hw_reset_pin_n, .dev_addr, .dev_wdata, .cmd_byte_enable_lines,
    .dev_wr, .dev_rd, .dev_ack, .dev_rdata);

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= wd;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] wd);
    logic [1:0] rs;
    axi_wr(a, wd, rs);
    check_val("bresp", 32'h0, {30'h0, rs});
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic [1:0]  rs;
    axi_rd(a, rd, rs);
    check_val(name, exp, rd);
  endtask

  // Polls status; gives up after 3000 reads
  task automatic wait_bit(input int pos, input logic val);
    logic [31:0] rd;
    logic [1:0]  rs;
    int          k;
    k = 0;
    do begin
      axi_rd(`CRI_OFS_STATUS, rd, rs);
      k++;
    end while (rd[pos] !== val && k < 3000);
    check_val("status bit", {31'h0, val}, {31'h0, rd[pos]});
  endtask
  task automatic dev_acc(input logic [15:0] a, input logic [15:0] wd, input logic rd);
    wr_ok(`CRI_OFS_ACC_ADDR, {15'h0, rd, a});
    wr_ok(`CRI_OFS_ACC_WDATA, {16'h0, wd});
    wr_ok(`CRI_OFS_ACC_GO, 32'h1);
    wait_bit(3, 1'b0);
  endtask

  task automatic final_report;
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    $display("Error watchdog expected finish seen hang");
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("idle status", `CRI_OFS_STATUS, 32'h0);
    check_val("config select", 32'h0, {31'h0, config_select_input});
    wr_ok(`CRI_OFS_BRIDGE, 32'h0000a5c3);
    rd_chk("bridge", `CRI_OFS_BRIDGE, 32'h0000a5c3);
    wr_ok(`CRI_OFS_MASK_LO, 32'h5);
    wr_ok(`CRI_OFS_MASK_HI, 32'h80);
    rd_chk("mask high", `CRI_OFS_MASK_HI, 32'h80);
    axi_wr(8'h24, 32'h1, r);
    check_val("unmapped bresp", 32'h2, {30'h0, r});
    axi_rd(8'h24, d, r);
    check_val("unmapped rresp", 32'h2, {30'h0, r});
    check_val("unmapped rdata", 32'h0, d);
    wr_ok(`CRI_OFS_ACC_GO, 32'h1);
    check_val("early access", 32'h0, i_crinit_dev_model.wlog.size());
    $display("Test registers done");
    wr_ok(`CRI_OFS_CTRL, 32'h1);
    wait_bit(2, 1'b1);
    check_val("bridge device", 32'ha5c3, {16'h0, i_crinit_dev_model.dreg[`CRI_DEV_BRIDGE >> 2]});
    check_val("config select", 32'h1, {31'h0, config_select_input});
    check_val("reset pulses", 32'h1, hw_falls);
    n = 0;
    for (int i = 0; i < 40; i++) n += i_crinit_dev_model.rx_en[i] + i_crinit_dev_model.tx_en[i];
    check_val("enables left", 32'h0, n);
    dev_acc(`CRI_DEV_MASTER_CFG, 16'h8100, 1'b0);
    dev_acc(`CRI_DEV_MASTER_CFG, 16'h0000, 1'b1);
    rd_chk("access read", `CRI_OFS_ACC_RDATA, 32'h8100);
    wr_ok(`CRI_OFS_CTRL, 32'h4);
    wait_bit(1, 1'b1);
    rd_chk("done status", `CRI_OFS_STATUS, 32'h00000c02);
    for (int i = 0; i < 40; i++) begin
      check_val("rx enable", {31'h0, i == 0 || i == 2 || i == 39}, {31'h0, i_crinit_dev_model.rx_en[i]});
      check_val("tx enable", {31'h0, i == 0 || i == 2 || i == 39}, {31'h0, i_crinit_dev_model.tx_en[i]});
    end
    check_val("master config", 32'h8103, {16'h0, i_crinit_dev_model.dreg[`CRI_DEV_MASTER_CFG >> 2]});
    check_val("write count", 32'd175, i_crinit_dev_model.wlog.size());
    foreach (ix[k]) check_val("write order", {16'h0, ex[k]}, {16'h0, i_crinit_dev_model.wlog[ix[k]]});
    $display("Test hardware reset start done");
    i_crinit_dev_model.wlog.delete();
    wr_ok(`CRI_OFS_CTRL, 32'h3);
    wait_bit(2, 1'b1);
    check_val("sw reset set", 32'h0, {16'h0, i_crinit_dev_model.wlog[0]});
    check_val("sw reset clear", 32'h0, {16'h0, i_crinit_dev_model.wlog[1]});
    check_val("bridge next", 32'h40, {16'h0, i_crinit_dev_model.wlog[2]});
    check_val("reset pulses", 32'h1, hw_falls);
    dev_acc(`CRI_DEV_MASTER_CFG, 16'h0000, 1'b1);
    rd_chk("cleared config", `CRI_OFS_ACC_RDATA, 32'h0);
    wr_ok(`CRI_OFS_CTRL, 32'h3);
    axi_rd(`CRI_OFS_STATUS, d, r);
    check_val("state code", 32'h7, {28'h0, d[11:8]});
    wr_ok(`CRI_OFS_CTRL, 32'h6);
    wait_bit(1, 1'b1);
    check_val("master config", 32'h3, {16'h0, i_crinit_dev_model.dreg[`CRI_DEV_MASTER_CFG >> 2]});
    check_val("bad accesses", 32'h0, i_crinit_dev_model.bad_cnt);
    $display("Test software reset start done");
    final_report();
  end
endmodule
